// ### bench/ncer_bus_model.sv
// Far-side bus model: another driver sharing the register's output lines
`timescale 1ns/1ps

module ncer_bus_model
    import ncer_pkg::*;
(
    // Clock
    input  wire logic                   ref_clk,
    // Register drivers
    input  wire logic [NCER_DATA_W-1:0] data_out,
    input  wire logic [NCER_DATA_W-1:0] data_out_oe,
    // Resolved bus
    output logic      [NCER_DATA_W-1:0] bus_line
);
    logic [NCER_DATA_W-1:0] other_r;

    // Other driver flips every cycle, so a stale register value never passes
    always_ff @(posedge ref_clk)
    begin
        other_r <= (other_r === 9'h0AA) ? 9'h155 : 9'h0AA;
    end

    // Per-bit resolution of the shared lines
    always_comb
    begin
        for (int i = 0; i < NCER_DATA_W; i++)
        begin
            bus_line[i] = data_out_oe[i] ? data_out[i] : other_r[i];
        end
    end
endmodule // ncer_bus_model

// ### bench/ncer_tb_top.sv
// Self-checking bench for the nine-bit clearable, enabled holding register
`timescale 1ns/1ps

module nine_bit_clear_enable_register_tb_top
    import ncer_pkg::*;
;
    logic                   ref_clk;
    logic                   rst_b;
    logic                   capture_clock;
    logic                   capture_en_n;
    logic                   register_zero_n;
    logic                   output_en_n;
    logic [NCER_DATA_W-1:0] data_in;
    logic [NCER_DATA_W-1:0] data_out;
    logic [NCER_DATA_W-1:0] data_out_oe;
    logic [NCER_DATA_W-1:0] bus_line;
    logic [NCER_DATA_W-1:0] pats [3] = '{9'h1A5, 9'h05A, 9'h100};
    int                     miscompares;
    int                     num_checks;

    ncer_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .capture_clock(capture_clock),
        .capture_en_n(capture_en_n), .register_zero_n(register_zero_n),
        .data_in(data_in), .output_en_n(output_en_n), .data_out(data_out),
        .data_out_oe(data_out_oe));
    ncer_bus_model i_bus (.ref_clk(ref_clk), .data_out(data_out),
        .data_out_oe(data_out_oe), .bus_line(bus_line));

    // 100 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Pins pass two sync flops plus one register stage, so five edges suffice
    task automatic set_pins(input logic en_n, input logic zero_n, input logic oe_n,
                            input logic [8:0] d);
        @(posedge ref_clk);
        capture_en_n    <= en_n;
        register_zero_n <= zero_n;
        output_en_n     <= oe_n;
        data_in         <= d;
        repeat (5) @(posedge ref_clk);
        #1;
    endtask

    // Capture pulse: both phases long enough to survive synchronisation
    task automatic pulse;
        @(posedge ref_clk);
        capture_clock <= 1'b1;
        repeat (4) @(posedge ref_clk);
        capture_clock <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    task automatic summarize;
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_load;
        foreach (pats[i])
        begin
            set_pins(1'b0, 1'b1, 1'b0, pats[i]);
            pulse();
            chk(data_out, pats[i], "loaded word");
            chk(bus_line, pats[i], "bus drives word");
            chk(data_out_oe, 9'h1FF, "drivers on");
        end
        $display("test load done");
    endtask

    task automatic t_hold;
        set_pins(1'b1, 1'b1, 1'b0, 9'h0F0);
        pulse();
        chk(data_out, 9'h100, "held word");
        $display("test hold done");
    endtask

    task automatic t_hiz;
        set_pins(1'b0, 1'b1, 1'b1, 9'h0C3);
        chk(data_out_oe, 9'h000, "drivers released");
        chk(data_out, 9'h100, "store kept when released");
        pulse();
        chk(data_out, 9'h0C3, "capture while released");
        set_pins(1'b0, 1'b1, 1'b0, 9'h0C3);
        chk(bus_line, 9'h0C3, "bus after re-enable");
        $display("test hiz done");
    endtask

    task automatic t_clear;
        set_pins(1'b0, 1'b0, 1'b0, 9'h1FF);
        chk(bus_line, 9'h000, "bus low under clear");
        pulse();
        chk(data_out, 9'h000, "no load under clear");
        set_pins(1'b0, 1'b1, 1'b0, 9'h1FF);
        chk(data_out, 9'h000, "zero kept until edge");
        pulse();
        chk(data_out, 9'h1FF, "load after clear");
        $display("test clear done");
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial
    begin
        rst_b           = 1'b0;
        capture_clock   = 1'b0;
        capture_en_n    = 1'b1;
        register_zero_n = 1'b1;
        output_en_n     = 1'b1;
        data_in         = 9'h000;
        repeat (7) @(posedge ref_clk);
        #1;
        chk(data_out_oe, 9'h000, "drivers off in reset");
        chk(data_out, 9'h000, "store zero in reset");
        @(posedge ref_clk);
        rst_b <= 1'b1;
        $display("test reset done");
        t_load();
        t_hold();
        t_hiz();
        t_clear();
        summarize();
    end

    // Whole run needs just over a microsecond; twenty is a generous ceiling
    initial
    begin
        #20000;
        miscompares++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end
endmodule // nine_bit_clear_enable_register_tb_top

// ### design/ncer_sync.sv
// Two-stage synchroniser for pin inputs entering the ref_clk domain
`timescale 1ns/1ps

module ncer_sync #(
    parameter int unsigned  W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    // Asynchronous level in, synchronised level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    // First stage feeds only the second stage, never any other logic
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule // ncer_sync

// ### design/ncer_top.sv
// Nine-bit edge-triggered holding register with clear, clock enable and bus drivers
// Contract
// - Nine storage elements, one clock, one enable
// - Rising capture edge stores each data input
// - Output enable low drives stored value out
// - Output enable high releases all nine drivers
// - Output enable never disturbs stored contents
// - Clear low forces every stored bit zero
// - New data accepted only while clear high
// - Enable low loads data on rising edge
// - Enable high holds value, ignores edges
`timescale 1ns/1ps

module ncer_top
    import ncer_pkg::*;
#(
    parameter int unsigned DATA_W = NCER_DATA_W
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    // Capture side pins
    input  wire logic              capture_clock,
    input  wire logic              capture_en_n,
    input  wire logic              register_zero_n,
    input  wire logic [DATA_W-1:0] data_in,
    // Bus side pins
    input  wire logic              output_en_n,
    output logic      [DATA_W-1:0] data_out,
    output logic      [DATA_W-1:0] data_out_oe
);

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************

    logic [NCER_CTRL_W-1:0] ctrl_s;
    logic [DATA_W-1:0]      data_s;
    logic                   clk_s;
    logic                   oe_n_s;
    logic                   en_n_s;
    logic                   zero_n_s;
    logic                   clk_prev_r;
    logic                   capture_edge;
    logic                   load_go;

    // Data and controls pass the same two stages, so a clock edge and the
    // data around it stay aligned; the cost is a fixed latency to the pins
    ncer_sync #(
        .W       (NCER_CTRL_W),
        .RST_VAL (NCER_CTRL_RST)
    ) u_ctrl_sync (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .d       ({register_zero_n, capture_en_n, output_en_n, capture_clock}),
        .q       (ctrl_s)
    );

    ncer_sync #(
        .W       (DATA_W),
        .RST_VAL (NCER_STORE_RST[DATA_W-1:0])
    ) u_data_sync (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .d       (data_in),
        .q       (data_s)
    );

    // Named views of the synchronised control vector
    assign clk_s    = ctrl_s[NCER_CTL_CLK];
    assign oe_n_s   = ctrl_s[NCER_CTL_OEN];
    assign en_n_s   = ctrl_s[NCER_CTL_ENN];
    assign zero_n_s = ctrl_s[NCER_CTL_ZERO];

    // ****************************************************************
    // Capture edge detection
    // ****************************************************************

    // Previous level of the synchronised capture clock
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            clk_prev_r <= 1'b0;
        else
            clk_prev_r <= clk_s;
    end

    // Only the low-to-high transition captures; a falling edge does nothing
    assign capture_edge = clk_s & ~clk_prev_r;
    assign load_go      = capture_edge & ~en_n_s & zero_n_s;

    // ****************************************************************
    // Storage
    // ****************************************************************

    // The stored word is the output register itself: clear has priority,
    // then a qualified edge loads, otherwise the value is held
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            data_out <= NCER_STORE_RST[DATA_W-1:0];
        else if (!zero_n_s)
            data_out <= NCER_STORE_RST[DATA_W-1:0];
        else if (load_go)
            data_out <= data_s;
    end

    // ****************************************************************
    // Bus drivers
    // ****************************************************************

    // One shared enable fans out to every bit; the store is not touched here
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++)
        begin : g_drv
            always_ff @(posedge ref_clk or negedge rst_b)
            begin
                if (!rst_b)
                    data_out_oe[gi] <= NCER_OE_RST[gi];
                else
                    data_out_oe[gi] <= ~oe_n_s;
            end
        end
    endgenerate

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // All bits switch together under the one buffered enable
    property p_shared_enable;
        (data_out_oe == '0) || (data_out_oe == '1);
    endproperty
    a_shared_enable: assert property (p_shared_enable)
        else $error("output enables of the bits disagree");

    // A qualified rising edge stores the data seen at that edge
    property p_edge_stores;
        capture_edge && !en_n_s && zero_n_s |=> data_out == $past(data_s);
    endproperty
    a_edge_stores: assert property (p_edge_stores)
        else $error("rising edge did not store the data inputs");

    // Enable low turns every driver on one cycle later
    property p_drive_on;
        !oe_n_s |=> data_out_oe == '1;
    endproperty
    a_drive_on: assert property (p_drive_on)
        else $error("drivers not on while output enable low");

    // Enable high releases every driver one cycle later and keeps it off
    property p_drive_off;
        oe_n_s ##1 oe_n_s |-> data_out_oe == '0;
    endproperty
    a_drive_off: assert property (p_drive_off)
        else $error("drivers not released while output enable high");

    // Toggling the output enable alone leaves the stored word alone
    property p_oe_no_effect;
        $changed(oe_n_s) && zero_n_s && !load_go |=> $stable(data_out);
    endproperty
    a_oe_no_effect: assert property (p_oe_no_effect)
        else $error("output enable changed the stored value");

    // Clear low gives zero on the next cycle
    property p_clear_zero;
        !zero_n_s |=> data_out == '0;
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("clear did not zero the register");

    // An edge under clear loads nothing, even with enable low
    property p_no_load_in_clear;
        !zero_n_s && capture_edge && !en_n_s |=> data_out == '0;
    endproperty
    a_no_load_in_clear: assert property (p_no_load_in_clear)
        else $error("data accepted while clear held low");

    // A loaded word reaches the pins one cycle after the edge once enabled
    property p_load_visible;
        load_go && !oe_n_s ##1 !oe_n_s |-> data_out == $past(data_s)
            && data_out_oe == '1;
    endproperty
    a_load_visible: assert property (p_load_visible)
        else $error("loaded data not visible at the outputs");

    // Enable high holds the word across edges and data changes
    property p_hold;
        en_n_s && zero_n_s |=> $stable(data_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("register changed while clock enable high");

    // Clear held low keeps the word at zero throughout, whatever else moves
    property p_clear_held;
        !zero_n_s [*3] |=> data_out == '0 && $stable(data_out);
    endproperty
    a_clear_held: assert property (p_clear_held)
        else $error("register left zero while clear held low");

    // Clear wins over any capture edge in the same cycle, enable or not
    property p_clear_priority;
        !zero_n_s && capture_edge |=> data_out == '0;
    endproperty
    a_clear_priority: assert property (p_clear_priority)
        else $error("capture edge overrode the clear");

    // The word is still zero in the cycle the clear lets go
    sequence s_clear_release;
        !zero_n_s ##1 zero_n_s;
    endsequence
    property p_clear_release_bounded;
        s_clear_release |-> data_out == '0;
    endproperty
    a_clear_release_bounded: assert property (p_clear_release_bounded)
        else $error("register not zero when clear released");

    // Main scenarios
    c_load:       cover property (load_go ##1 data_out != '0);
    c_hold_edge:  cover property (capture_edge && en_n_s && zero_n_s);
    c_clear_edge: cover property (capture_edge && !en_n_s && !zero_n_s);
    c_hiz_load:   cover property (load_go && oe_n_s ##2 !oe_n_s);

endmodule // ncer_top

// ### pkg/ncer_pkg.sv
// Shared constants for the nine-bit clearable, enabled holding register
package ncer_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int unsigned NCER_DATA_W  = 9;   // Storage elements in the register
    localparam int unsigned NCER_CTRL_W  = 4;   // Synchronised control pins

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [NCER_DATA_W-1:0] NCER_STORE_RST = 9'h000;
    localparam logic [NCER_DATA_W-1:0] NCER_OE_RST    = 9'h000;

    // Control pin sync reset: {zero_n, enable_n, out_en_n, clock}
    // Clear asserted and drivers released while the chip is in reset
    localparam logic [NCER_CTRL_W-1:0] NCER_CTRL_RST  = 4'h6;

    // ****************************************************************
    // Field positions inside the synchronised control vector
    // ****************************************************************
    localparam int unsigned NCER_CTL_CLK  = 0;
    localparam int unsigned NCER_CTL_OEN  = 1;
    localparam int unsigned NCER_CTL_ENN  = 2;
    localparam int unsigned NCER_CTL_ZERO = 3;

endpackage : ncer_pkg
